// ---- shutdown_request_input_pkg.sv ----
package shutdown_request_input_pkg;

    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h00;
    localparam logic [7:0] EVT_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] EVT_MASK_OFFSET = 8'h08;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NUM_PINS = 3;

    // field positions inside input_level_ctrl_status
    localparam int PIN3_FLAG_BIT = 15;
    localparam int PIN1_FLAG_BIT = 13;
    localparam int PIN0_FLAG_BIT = 12;
    localparam int IRQ_ENABLE_BIT = 8;
    localparam int PIN3_MODE_LSB = 6;
    localparam int PIN1_MODE_LSB = 2;
    localparam int PIN0_MODE_LSB = 0;

    // reset values
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

    // input mode encodings
    localparam logic [1:0] MODE_FALLING_EDGE = 2'h0;
    localparam logic [1:0] MODE_SAMPLE_DIV8 = 2'h1;
    localparam logic [1:0] MODE_SAMPLE_DIV16 = 2'h2;
    localparam logic [1:0] MODE_SAMPLE_DIV128 = 2'h3;

    // sampling timing
    localparam int PRESCALE_W = 7;
    localparam logic [PRESCALE_W-1:0] DIV8_MASK = 7'h07;
    localparam logic [PRESCALE_W-1:0] DIV16_MASK = 7'h0F;
    localparam logic [PRESCALE_W-1:0] DIV128_MASK = 7'h7F;
    localparam int LOW_CNT_W = 5;
    localparam logic [LOW_CNT_W-1:0] LOW_SAMPLES_NEEDED = 5'h10;

endpackage : shutdown_request_input_pkg

// ---- shutdown_request_input_ctrl.sv ----
// Implementation choices: strobed register access and the address map.
`timescale 1ns/10ps
// Summary of operation
// [RULE1] The shared shutdown interrupt is raised while the enable bit is 1 and any request flag is set, never when 0; unmasked events raise it even when 0.
// [RULE2] Pin3 mode 00 accepts a request on a falling edge of the pin3 input.
// [RULE3] Pin3 mode 01 accepts a request when 16 samples at the clock divided by eight are all low.
// [RULE4] Pin3 mode 10 accepts a request after 16 consecutive low samples at the clock divided by sixteen.
// [RULE5] On a variant without the pin3 input, software writes 00 to the pin3 mode field.
// [RULE6] Pin1 mode 00 accepts a request on a falling edge of the pin1 input.
// [RULE7] Pin1 mode using the clock divided by sixteen accepts a request after 16 consecutive low samples.
// [RULE8] Bits 5 and 4 of the control/status register read as 0 and software writes only 0 there.
// [RULE9] The mode fields accept only one write after reset; later writes leave them unchanged.
// [RULE10] A request flag clears only by writing 0 after reading it as 1; writing 1 does nothing.
// [RULE11] Sampling modes divide the clock by 8, 16 or 128, encoding 11 selecting 128.
// [RULE12] A high sample restarts the low count and the flag sets when the count reaches sixteen.
module shutdown_request_input_ctrl
    import shutdown_request_input_pkg::*;
(
    input wire logic i_clk, // 40 MHz peripheral clock
    input wire logic i_rst, // asynchronous reset, active high
    input wire logic i_ce, // clock enable, freezes all state when low
    input wire logic i_shutdown_request_pin0_n, // pin0 request, active low
    input wire logic i_shutdown_request_pin1_n, // pin1 request, active low
    input wire logic i_shutdown_request_pin3_n, // pin3 request, active low
    input wire logic [ADDR_W-1:0] i_addr, // register byte address
    input wire logic [DATA_W-1:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [DATA_W-1:0] o_rdata, // read data, valid the cycle after i_rd
    output logic o_irq // level interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [1:0] mode_field(input logic [DATA_W-1:0] word, input int idx);
        logic [1:0] f;
        f = 2'h0;
        unique case (idx)
            0: f = word[PIN0_MODE_LSB +: 2];
            1: f = word[PIN1_MODE_LSB +: 2];
            default: f = word[PIN3_MODE_LSB +: 2];
        endcase
        return f;
    endfunction : mode_field

    function automatic int flag_pos(input int idx);
        int p;
        p = PIN3_FLAG_BIT;
        if (idx == 0) begin
            p = PIN0_FLAG_BIT;
        end else if (idx == 1) begin
            p = PIN1_FLAG_BIT;
        end
        return p;
    endfunction : flag_pos

    function automatic logic sample_tick(input logic [1:0] mode, input logic [PRESCALE_W-1:0] pre);
        logic t;
        t = 1'b0;
        unique case (mode)
            MODE_SAMPLE_DIV8: t = ((pre & DIV8_MASK) == DIV8_MASK);
            MODE_SAMPLE_DIV16: t = ((pre & DIV16_MASK) == DIV16_MASK);
            MODE_SAMPLE_DIV128: t = (pre == DIV128_MASK); // [RULE11]
            MODE_FALLING_EDGE: t = 1'b0;
        endcase
        return t;
    endfunction : sample_tick

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic wr_ctrl;
    logic rd_ctrl;
    logic wr_evt;
    logic wr_mask;
    logic [NUM_PINS-1:0] pin_n;
    logic [NUM_PINS-1:0] flag_q;
    logic [NUM_PINS-1:0] armed_q;
    logic [NUM_PINS-1:0] detect;
    logic [NUM_PINS-1:0] evt_q;
    logic [NUM_PINS-1:0] mask_q;
    logic [1:0] mode_q [NUM_PINS];
    logic irq_enable_q;
    logic modes_locked_q;
    logic [PRESCALE_W-1:0] prescale_q;
    logic [DATA_W-1:0] ctrl_word;

    assign wr_ctrl = i_wr && (i_addr == CTRL_STATUS_OFFSET);
    assign rd_ctrl = i_rd && (i_addr == CTRL_STATUS_OFFSET);
    assign wr_evt = i_wr && (i_addr == EVT_STATUS_OFFSET);
    assign wr_mask = i_wr && (i_addr == EVT_MASK_OFFSET);
    assign pin_n = {i_shutdown_request_pin3_n, i_shutdown_request_pin1_n, i_shutdown_request_pin0_n};

    always_comb begin
        ctrl_word = REG_RESET; // reserved bits stay 0
        ctrl_word[IRQ_ENABLE_BIT] = irq_enable_q;
        for (int k = 0; k < NUM_PINS; k++) begin
            ctrl_word[flag_pos(k)] = flag_q[k];
        end
        ctrl_word[PIN0_MODE_LSB +: 2] = mode_q[0];
        ctrl_word[PIN1_MODE_LSB +: 2] = mode_q[1];
        ctrl_word[PIN3_MODE_LSB +: 2] = mode_q[2]; // [RULE8]
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= REG_RESET;
        end else if (i_ce) begin
            if (i_rd) begin
                unique case (i_addr)
                    CTRL_STATUS_OFFSET: o_rdata <= ctrl_word; // [RULE8]
                    EVT_STATUS_OFFSET: o_rdata <= {{(DATA_W-NUM_PINS){1'b0}}, evt_q};
                    EVT_MASK_OFFSET: o_rdata <= {{(DATA_W-NUM_PINS){1'b0}}, mask_q};
                    default: o_rdata <= REG_RESET;
                endcase
            end else begin
                o_rdata <= REG_RESET;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_enable_q <= 1'b0;
        end else if (i_ce && wr_ctrl) begin
            irq_enable_q <= i_wdata[IRQ_ENABLE_BIT];
        end
    end

    // mode fields take the first control write only
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            modes_locked_q <= 1'b0;
            for (int k = 0; k < NUM_PINS; k++) begin
                mode_q[k] <= MODE_RESET;
            end
        end else if (i_ce && wr_ctrl && !modes_locked_q) begin
            modes_locked_q <= 1'b1; // [RULE9]
            for (int k = 0; k < NUM_PINS; k++) begin
                mode_q[k] <= mode_field(i_wdata, k);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_q <= '0;
        end else if (i_ce && wr_mask) begin
            mask_q <= i_wdata[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prescale_q <= '0;
        end else if (i_ce) begin
            prescale_q <= prescale_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-pin detection and flags

    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        logic prev_q;
        logic tick;
        logic [LOW_CNT_W-1:0] low_cnt_q;
        logic clr;

        assign tick = sample_tick(mode_q[g], prescale_q);
        assign clr = wr_ctrl && !i_wdata[flag_pos(g)] && armed_q[g];

        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                prev_q <= 1'b1;
            end else if (i_ce) begin
                prev_q <= pin_n[g];
            end
        end

        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                low_cnt_q <= '0;
            end else if (i_ce && tick) begin
                if (pin_n[g]) begin
                    low_cnt_q <= '0; // [RULE12]
                end else if (low_cnt_q != LOW_SAMPLES_NEEDED) begin
                    low_cnt_q <= low_cnt_q + 5'h01; // [RULE3] [RULE4] [RULE7]
                end
            end
        end

        always_comb begin
            if (mode_q[g] == MODE_FALLING_EDGE) begin
                detect[g] = prev_q && !pin_n[g]; // [RULE2] [RULE6]
            end else begin
                detect[g] = tick && !pin_n[g] && (low_cnt_q == LOW_SAMPLES_NEEDED - 5'h01); // [RULE12]
            end
        end

        // a new detection wins over a clear in the same cycle
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                flag_q[g] <= 1'b0;
                armed_q[g] <= 1'b0;
            end else if (i_ce) begin
                if (detect[g]) begin
                    flag_q[g] <= 1'b1;
                    armed_q[g] <= 1'b0;
                end else if (clr) begin
                    flag_q[g] <= 1'b0; // [RULE10]
                    armed_q[g] <= 1'b0;
                end else if (rd_ctrl && flag_q[g]) begin
                    armed_q[g] <= 1'b1; // [RULE10]
                end
            end
        end

        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                evt_q[g] <= 1'b0;
            end else if (i_ce) begin
                if (detect[g]) begin
                    evt_q[g] <= 1'b1;
                end else if (wr_evt && i_wdata[g]) begin
                    evt_q[g] <= 1'b0;
                end
            end
        end

        a_edge_detect: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE2]
            i_ce && mode_q[g] == MODE_FALLING_EDGE && prev_q && !pin_n[g] |=> flag_q[g])
            else $error("falling edge did not set the flag");
        a_low_restart: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE12]
            i_ce && tick && pin_n[g] |=> low_cnt_q == 5'h00)
            else $error("high sample did not restart the low count");
        a_sample_set: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE3]
            i_ce && tick && !pin_n[g] && low_cnt_q == 5'h0F |=> flag_q[g] && low_cnt_q == 5'h10)
            else $error("sixteenth low sample did not set the flag");
        a_count_bound: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE4]
            low_cnt_q <= 5'h10)
            else $error("low count ran past sixteen");
        a_flag_keep: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE10]
            i_ce && wr_ctrl && i_wdata[flag_pos(g)] && flag_q[g] |=> flag_q[g])
            else $error("writing one changed the flag");
        a_clear_read: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE10]
            $fell(flag_q[g]) |-> $past(armed_q[g]) && $past(wr_ctrl))
            else $error("flag cleared without a prior read of one");
        a_div128_tick: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE11]
            mode_q[g] == MODE_SAMPLE_DIV128 && tick |-> prescale_q == 7'h7F)
            else $error("divide by 128 sampled at the wrong time");
        a_div8_tick: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE3]
            mode_q[g] == MODE_SAMPLE_DIV8 && tick |-> prescale_q[2:0] == 3'h7)
            else $error("divide by 8 sampled at the wrong time");
        a_div16_tick: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE4] [RULE7]
            mode_q[g] == MODE_SAMPLE_DIV16 && tick |-> prescale_q[3:0] == 4'hF)
            else $error("divide by 16 sampled at the wrong time");
        a_edge_only: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE6]
            i_ce && mode_q[g] == MODE_FALLING_EDGE && !flag_q[g] && !(prev_q && !pin_n[g]) |=> !flag_q[g])
            else $error("flag set without a falling edge");
        a_sample_only: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE12]
            i_ce && mode_q[g] != MODE_FALLING_EDGE && !flag_q[g] |=> !flag_q[g] || low_cnt_q == 5'h10)
            else $error("flag set before sixteen low samples");
        a_set_wins: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE10]
            i_ce && detect[g] |=> flag_q[g] && !armed_q[g])
            else $error("clear beat a detection in the same cycle");
        a_arm_read: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE10]
            i_ce && rd_ctrl && flag_q[g] && !detect[g] && !clr |=> armed_q[g])
            else $error("read of a set flag did not arm its clear");
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt

    assign o_irq = (irq_enable_q && (|flag_q)) || (|(evt_q & mask_q)); // [RULE1]

    a_irq_disabled: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE1]
        !irq_enable_q && !(|(evt_q & mask_q)) |-> !o_irq)
        else $error("interrupt raised while disabled");
    a_irq_flagged: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE1]
        irq_enable_q && (|flag_q) |-> o_irq)
        else $error("interrupt missing with a flag set");
    a_mode_locked: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE9]
        modes_locked_q && wr_ctrl |=> $stable(mode_q[0]) && $stable(mode_q[1]) && $stable(mode_q[2]))
        else $error("mode field changed after the first write");
    a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE8]
        i_ce && rd_ctrl |=> o_rdata[5:4] == 2'h0 && o_rdata[14] == 1'b0 && o_rdata[11:9] == 3'h0)
        else $error("reserved bits read nonzero");
    a_enable_write: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE1]
        i_ce && wr_ctrl |=> irq_enable_q == $past(i_wdata[IRQ_ENABLE_BIT]))
        else $error("enable bit did not take the written value");
    a_first_write: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE9]
        i_ce && wr_ctrl && !modes_locked_q |=> modes_locked_q && mode_q[2] == $past(i_wdata[7:6]))
        else $error("first control write did not set the modes");
    a_irq_event: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE1]
        (|(evt_q & mask_q)) |-> o_irq)
        else $error("interrupt missing with an unmasked event");
    a_prescale_hold: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE11]
        !i_ce |=> $stable(prescale_q))
        else $error("prescaler moved while the clock enable was low");

endmodule : shutdown_request_input_ctrl

// ---- shutdown_pins_model.sv ----
`timescale 1ns/10ps
module shutdown_pins_model (
    input wire logic i_clk, // bench clock
    input wire logic i_go, // start one low period
    input wire logic [1:0] i_pin_sel, // 0 pin0, 1 pin1, 2 pin3
    input wire logic [11:0] i_low_len, // cycles held low
    output logic o_pin0_n, // pin0 request line
    output logic o_pin1_n, // pin1 request line
    output logic o_pin3_n // pin3 request line
);
    logic [11:0] low_cnt_q = 12'h000;
    logic [1:0] sel_q = 2'h0;

    always @(posedge i_clk) begin
        if (i_go) begin
            low_cnt_q <= i_low_len;
            sel_q <= i_pin_sel;
        end else if (low_cnt_q != 12'h000) begin
            low_cnt_q <= low_cnt_q - 12'h001;
        end
    end

    // lines are pulled up, so a released line reads high
    assign o_pin0_n = !(low_cnt_q != 12'h000 && sel_q == 2'h0);
    assign o_pin1_n = !(low_cnt_q != 12'h000 && sel_q == 2'h1);
    assign o_pin3_n = !(low_cnt_q != 12'h000 && sel_q == 2'h2);
endmodule : shutdown_pins_model

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
    import shutdown_request_input_pkg::*;
    typedef struct packed {logic [1:0] sel; logic [1:0] mode; logic [11:0] len; logic flag;} row_t;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic go = 1'b0;
    logic [1:0] pin_sel = 2'h0;
    logic [11:0] low_len = 12'h000;
    logic [ADDR_W-1:0] i_addr = 8'h00;
    logic [DATA_W-1:0] i_wdata = 16'h0000;
    logic [DATA_W-1:0] o_rdata;
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] exp_w;
    logic o_irq;
    logic p0_n;
    logic p1_n;
    logic p3_n;
    int errors = 0;
    int samples_checked = 0;
    int lsb;
    int fb;
    row_t rows [0:15] = '{
        '{2'h2, 2'h0, 12'h003, 1'b1}, '{2'h2, 2'h1, 12'h088, 1'b1}, '{2'h2, 2'h1, 12'h077, 1'b0},
        '{2'h2, 2'h2, 12'h110, 1'b1}, '{2'h2, 2'h2, 12'h0EF, 1'b0}, '{2'h2, 2'h3, 12'h880, 1'b1},
        '{2'h2, 2'h3, 12'h77F, 1'b0}, '{2'h1, 2'h0, 12'h002, 1'b1}, '{2'h1, 2'h2, 12'h110, 1'b1},
        '{2'h1, 2'h2, 12'h0EF, 1'b0}, '{2'h0, 2'h0, 12'h002, 1'b1}, '{2'h1, 2'h1, 12'h088, 1'b1},
        '{2'h1, 2'h3, 12'h880, 1'b1}, '{2'h0, 2'h1, 12'h088, 1'b1}, '{2'h0, 2'h2, 12'h0EF, 1'b0},
        '{2'h0, 2'h3, 12'h880, 1'b1}};

    always #12.5 i_clk = ~i_clk;

    shutdown_request_input_ctrl u_shutdown_request_input_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_shutdown_request_pin0_n(p0_n), .i_shutdown_request_pin1_n(p1_n), .i_shutdown_request_pin3_n(p3_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
    shutdown_pins_model u_shutdown_pins_model (.i_clk(i_clk), .i_go(go), .i_pin_sel(pin_sel),
        .i_low_len(low_len), .o_pin0_n(p0_n), .o_pin1_n(p1_n), .o_pin3_n(p3_n));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            errors++;
            $display("mismatch t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask : check

    task automatic do_reset;
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd

    task automatic pulse(input logic [1:0] s, input logic [11:0] n);
        int k;
        @(posedge i_clk);
        go <= 1'b1;
        pin_sel <= s;
        low_len <= n;
        @(posedge i_clk);
        go <= 1'b0;
        for (k = 0; k < 3000 && !(p0_n && p1_n && p3_n && k > 0); k++) @(posedge i_clk);
        if (k >= 3000) begin
            errors++;
            print_verdict();
        end
        repeat (4) @(posedge i_clk);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(CTRL_STATUS_OFFSET, v);
        check(v, REG_RESET);
        rd(EVT_STATUS_OFFSET, v);
        check(v, REG_RESET);
        rd(EVT_MASK_OFFSET, v);
        check(v, REG_RESET);
        rd(8'h0C, v);
        check(v, 16'h0000);
        foreach (rows[i]) begin
            lsb = (rows[i].sel == 2'h2) ? PIN3_MODE_LSB : (rows[i].sel == 2'h1) ? PIN1_MODE_LSB : PIN0_MODE_LSB;
            fb = (rows[i].sel == 2'h2) ? PIN3_FLAG_BIT : (rows[i].sel == 2'h1) ? PIN1_FLAG_BIT : PIN0_FLAG_BIT;
            exp_w = (16'(rows[i].mode) << lsb) | (16'(rows[i].flag) << fb);
            do_reset();
            wr(CTRL_STATUS_OFFSET, 16'(rows[i].mode) << lsb);
            pulse(rows[i].sel, rows[i].len);
            rd(CTRL_STATUS_OFFSET, v);
            check(v, exp_w);
            check({15'h0000, o_irq}, 16'h0000);
        end
        do_reset();
        wr(CTRL_STATUS_OFFSET, 16'h0000);
        wr(CTRL_STATUS_OFFSET, 16'h0044);
        rd(CTRL_STATUS_OFFSET, v);
        check(v, 16'h0000);
        pulse(2'h2, 12'h003);
        pulse(2'h2, 12'h003);
        wr(CTRL_STATUS_OFFSET, 16'h0000);
        rd(CTRL_STATUS_OFFSET, v);
        check(v, 16'h8000);
        wr(CTRL_STATUS_OFFSET, 16'h8000);
        rd(CTRL_STATUS_OFFSET, v);
        check(v, 16'h8000);
        wr(CTRL_STATUS_OFFSET, 16'h0000);
        rd(CTRL_STATUS_OFFSET, v);
        check(v, 16'h0000);
        pulse(2'h2, 12'h003);
        wr(CTRL_STATUS_OFFSET, 16'h0100);
        #1;
        check({15'h0000, o_irq}, 16'h0001);
        rd(CTRL_STATUS_OFFSET, v);
        check(v, 16'h8100);
        wr(CTRL_STATUS_OFFSET, 16'h0100);
        #1;
        check({15'h0000, o_irq}, 16'h0000);
        rd(EVT_STATUS_OFFSET, v);
        check(v, 16'h0004);
        wr(EVT_MASK_OFFSET, 16'h0004);
        #1;
        check({15'h0000, o_irq}, 16'h0001);
        wr(EVT_STATUS_OFFSET, 16'h0004);
        #1;
        check({15'h0000, o_irq}, 16'h0000);
        rd(EVT_STATUS_OFFSET, v);
        check(v, 16'h0000);
        // clock enable low freezes the edge detector, so a pulse leaves no trace
        @(posedge i_clk);
        i_ce <= 1'b0;
        pulse(2'h2, 12'h003);
        i_ce <= 1'b1;
        rd(CTRL_STATUS_OFFSET, v);
        check(v, 16'h0100);
        check({15'h0000, o_irq}, 16'h0000);
        print_verdict();
    end
endmodule : testbench
